// File: vfms_pkg.sv
// Constants, register map and shared types of the V/F base and multi-speed block.
package vfms_pkg;
  localparam int NTERM = 5;
  localparam int FN_W = 4;
  localparam int SET_W = 14;
  localparam int VOUT_W = 10;
  localparam int NSPEED = 15;
  localparam int RATIO_FRAC = 12;
  localparam int RATIO_W = 13;
  localparam int DIV_NW = SET_W + RATIO_FRAC;
  // Frequencies are in 0.1 Hz steps, voltages in whole volts.
  localparam logic [13:0] CODE_OFF = 14'h270F;
  localparam logic [13:0] CODE_SUPPLY95 = 14'h22B8;
  localparam logic [13:0] FREQ_MAX = 14'h0FA0;
  localparam logic [13:0] VOLT_MAX = 14'h03E8;
  localparam logic [16:0] SUPPLY95_PCT = 17'h0005F;
  localparam logic [16:0] PCT_FULL = 17'h00064;
  localparam logic [13:0] BASE_FREQ_RST = 14'h0258;
  localparam logic [13:0] BASE_VOLT_RST = 14'h270F;
  localparam logic [13:0] BASE_FREQ2_RST = 14'h270F;
  localparam logic [13:0] SPEED_HIGH_RST = 14'h0258;
  localparam logic [13:0] SPEED_MID_RST = 14'h012C;
  localparam logic [13:0] SPEED_LOW_RST = 14'h0064;
  localparam logic [13:0] SPEED_EXT_RST = 14'h270F;
  localparam logic LOAD_PAT_RST = 1'b1;
  localparam logic EXT_SEL_RST = 1'b0;
  localparam logic WR_SEL_RST = 1'b0;
  localparam logic [3:0] FN_LOW = 4'h0;
  localparam logic [3:0] FN_MID = 4'h1;
  localparam logic [3:0] FN_HIGH = 4'h2;
  localparam logic [3:0] FN_SECOND = 4'h3;
  localparam logic [3:0] FN_EXTRA = 4'h8;
  localparam logic [19:0] TERMFN_RST = 20'h83210;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TERMFN = 8'h04;
  localparam logic [7:0] OFS_BASE_FREQ = 8'h08;
  localparam logic [7:0] OFS_BASE_VOLT = 8'h0C;
  localparam logic [7:0] OFS_BASE_FREQ2 = 8'h10;
  localparam logic [7:0] OFS_LOAD = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_VOUT = 8'h1C;
  localparam logic [7:0] OFS_SPEED = 8'h20;
  localparam logic [7:0] OFS_SPEED_LAST = 8'h58;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_WSEL_BIT = 1;
  localparam int STAT_SPEED_LSB = 16;
  localparam int STAT_SECOND_BIT = 24;
  localparam logic [3:0] SPEED_EXT_FIRST = 4'h3;
  localparam logic [3:0] SPEED_NO_HIGH = 4'h1;
  localparam logic [3:0] SPEED_NO_MID = 4'h2;
  localparam logic [3:0] SPEED_NO_LOW = 4'h3;
  localparam logic [3:0] SPEED_NO_EIGHT = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic high;
    logic mid;
    logic low;
    logic extra;
    logic second;
  } vfms_sel_t;

  typedef enum logic [2:0] {
    VS_IDLE = 3'h1,
    VS_DIV = 3'h2,
    VS_OUT = 3'h4
  } vfms_vstate_t;
endpackage

// File: vfms_div.sv
// Sequential restoring divider that forms the frequency-to-base ratio.
`timescale 1ns/1ps
module vfms_div import vfms_pkg::*; #(
  parameter int NW = DIV_NW,
  parameter int DW = SET_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic [NW-1:0] quot,
  output logic done
);
  typedef struct packed {
    logic [NW-1:0] q;
    logic [DW:0] rem;
    logic [5:0] cnt;
    logic busy;
    logic done;
  } vfms_div_st_t;

  vfms_div_st_t st;
  vfms_div_st_t next_st;

  always_comb begin
    logic [DW:0] tmp;
    tmp = '0;
    next_st = st;
    next_st.done = 1'b0;
    if (start && !st.busy) begin
      next_st.q = num;
      next_st.rem = '0;
      next_st.cnt = 6'(NW);
      next_st.busy = 1'b1;
    end else if (st.busy) begin
      tmp = {st.rem[DW-1:0], st.q[NW-1]};
      if (tmp >= {1'b0, den}) begin
        next_st.rem = tmp - {1'b0, den};
        next_st.q = {st.q[NW-2:0], 1'b1};
      end else begin
        next_st.rem = tmp;
        next_st.q = {st.q[NW-2:0], 1'b0};
      end
      next_st.cnt = st.cnt - 6'h01;
      if (st.cnt == 6'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign quot = st.q;
  assign done = st.done;
endmodule

// File: vfms_core.sv
// V/F pattern and multi-speed frequency selection with an AXI4-Lite slave.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module vfms_core import vfms_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [NTERM-1:0] term_in,
  input wire logic motor_running,
  input wire logic jog_active,
  input wire logic [SET_W-1:0] jog_freq,
  input wire logic [SET_W-1:0] analog1_freq,
  input wire logic [SET_W-1:0] analog2_freq,
  input wire logic analog2_valid,
  input wire logic [SET_W-1:0] out_freq,
  input wire logic [VOUT_W-1:0] supply_volt,
  output logic [SET_W-1:0] freq_cmd,
  output logic [3:0] speed_no,
  output logic [VOUT_W-1:0] volt_cmd,
  output logic second_set
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_full;
    logic w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic ext_sel;
    logic wr_sel;
    logic load_pat;
    logic [NTERM*FN_W-1:0] termfn;
    logic [NSPEED-1:0][SET_W-1:0] speed;
    logic [SET_W-1:0] bfreq;
    logic [SET_W-1:0] bvolt;
    logic [SET_W-1:0] bfreq2;
    logic [SET_W-1:0] freq_cmd;
    logic [3:0] speed_no;
    logic second_set;
    vfms_vstate_t vst;
    logic div_go;
    logic [SET_W-1:0] vf;
    logic [SET_W-1:0] vbf;
    logic [VOUT_W-1:0] vbase;
    logic [RATIO_W-1:0] ratio;
    logic [VOUT_W-1:0] volt_cmd;
  } vfms_st_t;

  vfms_st_t st;
  vfms_st_t next_st;
  vfms_sel_t sel;
  logic [SET_W-1:0] eff_bf;
  logic [VOUT_W-1:0] eff_vb;
  logic [VOUT_W-1:0] v95;
  logic [DIV_NW-1:0] quot;
  logic div_done;
  logic wr_do;
  logic [7:0] wr_a;

  function automatic logic term_has(logic [NTERM*FN_W-1:0] fns,
                                    logic [NTERM-1:0] pins,
                                    logic [3:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (fns[i*FN_W +: FN_W] == code && pins[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic is_speed(logic [7:0] a);
    return a >= OFS_SPEED && a <= OFS_SPEED_LAST;
  endfunction

  function automatic logic [3:0] speed_idx(logic [7:0] a);
    return 4'((a - OFS_SPEED) >> 2);
  endfunction

  function automatic logic mapped(logic [7:0] a);
    return a <= OFS_VOUT || is_speed(a);
  endfunction

  function automatic logic is_ext(logic [7:0] a);
    return a == OFS_BASE_VOLT || a == OFS_BASE_FREQ2 || a == OFS_LOAD ||
      (is_speed(a) && speed_idx(a) >= SPEED_EXT_FIRST);
  endfunction

  function automatic logic [31:0] reg_read(logic [7:0] a, vfms_st_t s);
    logic [31:0] d;
    d = '0;
    if (is_speed(a)) begin
      d = 32'(s.speed[speed_idx(a)]);
    end else begin
      unique case (a)
        OFS_CTRL: begin
          d[CTRL_EXT_BIT] = s.ext_sel;
          d[CTRL_WSEL_BIT] = s.wr_sel;
        end
        OFS_TERMFN: d = 32'(s.termfn);
        OFS_BASE_FREQ: d = 32'(s.bfreq);
        OFS_BASE_VOLT: d = 32'(s.bvolt);
        OFS_BASE_FREQ2: d = 32'(s.bfreq2);
        OFS_LOAD: d = 32'(s.load_pat);
        OFS_STATUS: begin
          d[SET_W-1:0] = s.freq_cmd;
          d[STAT_SPEED_LSB +: 4] = s.speed_no;
          d[STAT_SECOND_BIT] = s.second_set;
        end
        OFS_VOUT: d = 32'(s.volt_cmd);
        default: d = '0;
      endcase
    end
    return d;
  endfunction

  // Settings above the range are refused rather than clipped, so software
  // reads back the stored value; a base voltage above supply_volt is used as supply_volt.
  function automatic logic legal(logic [7:0] a, logic [31:0] d);
    logic [SET_W-1:0] v;
    logic ok;
    v = d[SET_W-1:0];
    ok = 1'b1;
    if (a == OFS_TERMFN) begin
      ok = d[31:NTERM*FN_W] == '0;
    end else if (d[31:SET_W] != '0) begin
      ok = 1'b0;
    end else if (a == OFS_BASE_VOLT) begin
      ok = v <= VOLT_MAX || v == CODE_SUPPLY95 || v == CODE_OFF;
    end else if (a == OFS_BASE_FREQ2 || (is_speed(a) && is_ext(a))) begin
      ok = v <= FREQ_MAX || v == CODE_OFF;
    end else if (a == OFS_BASE_FREQ || is_speed(a)) begin
      ok = v <= FREQ_MAX;
    end
    return ok;
  endfunction

  // fixed combination table; 0 means no preset input is on.
  function automatic logic [3:0] speed_code(logic ex, logic h, logic m,
                                            logic l);
    logic [3:0] c;
    unique case ({ex, h, m, l})
      4'h4: c = 4'h1;
      4'h2: c = 4'h2;
      4'h1: c = 4'h3;
      // Middle plus low takes speed 4, so every preset 4 to 15 has a code.
      4'h3: c = 4'h4;
      4'h0: c = 4'h0;
      default: c = {ex, h, m, l};
    endcase
    if ({ex, h, m, l} == 4'h8) begin
      c = SPEED_NO_EIGHT;
    end
    return c;
  endfunction

  always_comb begin
    sel.low = term_has(st.termfn, term_in, FN_LOW);
    sel.mid = term_has(st.termfn, term_in, FN_MID);
    sel.high = term_has(st.termfn, term_in, FN_HIGH);
    sel.extra = term_has(st.termfn, term_in, FN_EXTRA);
    sel.second = term_has(st.termfn, term_in, FN_SECOND);
  end

  assign eff_bf = (st.second_set && st.bfreq2 != CODE_OFF) ?
    st.bfreq2 : st.bfreq;
  assign v95 = VOUT_W'(({7'h00, supply_volt} * SUPPLY95_PCT) / PCT_FULL);

  always_comb begin
    if (st.bvolt == CODE_SUPPLY95) begin
      eff_vb = v95;
    end else if (st.bvolt == CODE_OFF) begin
      eff_vb = supply_volt;
    end else if (st.bvolt < 14'(supply_volt)) begin
      eff_vb = st.bvolt[VOUT_W-1:0];
    end else begin
      eff_vb = supply_volt;
    end
  end

  assign wr_do = st.aw_full && st.w_full && !st.bvalid;
  assign wr_a = {st.awaddr[7:2], 2'h0};

  always_comb begin
    logic [31:0] d;
    logic [31:0] m;
    logic [7:0] ra;
    logic [3:0] c;
    logic [35:0] p;
    logic [35:0] p2;
    d = '0;
    m = '0;
    ra = '0;
    c = '0;
    p = '0;
    p2 = '0;
    next_st = st;
    if (awvalid && st.awready) begin
      next_st.awready = 1'b0;
      next_st.aw_full = 1'b1;
      next_st.awaddr = awaddr;
    end
    if (wvalid && st.wready) begin
      next_st.wready = 1'b0;
      next_st.w_full = 1'b1;
      next_st.wdata = wdata;
      next_st.wstrb = wstrb;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
    end
    if (wr_do) begin
      for (int i = 0; i < 4; i++) begin
        m[i*8 +: 8] = {8{st.wstrb[i]}};
      end
      d = (reg_read(wr_a, st) & ~m) | (st.wdata & m);
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_SLVERR;
      if (!mapped(wr_a) || wr_a == OFS_STATUS || wr_a == OFS_VOUT) begin
        next_st.bresp = RESP_SLVERR;
      end else if (is_ext(wr_a) && st.ext_sel) begin
        next_st.bresp = RESP_SLVERR;
      end else if (wr_a != OFS_CTRL && !is_speed(wr_a) && motor_running &&
                   !st.wr_sel) begin
        next_st.bresp = RESP_SLVERR;
      end else if (legal(wr_a, d)) begin
        next_st.bresp = RESP_OKAY;
        if (is_speed(wr_a)) begin
          next_st.speed[speed_idx(wr_a)] = d[SET_W-1:0];
        end else begin
          unique case (wr_a)
            OFS_CTRL: begin
              next_st.ext_sel = d[CTRL_EXT_BIT];
              next_st.wr_sel = d[CTRL_WSEL_BIT];
            end
            OFS_TERMFN: next_st.termfn = d[NTERM*FN_W-1:0];
            OFS_BASE_FREQ: next_st.bfreq = d[SET_W-1:0];
            OFS_BASE_VOLT: next_st.bvolt = d[SET_W-1:0];
            OFS_BASE_FREQ2: next_st.bfreq2 = d[SET_W-1:0];
            OFS_LOAD: next_st.load_pat = d[0];
            default: next_st.bresp = RESP_SLVERR;
          endcase
        end
      end
    end
    if (arvalid && st.arready) begin
      ra = {araddr[7:2], 2'h0};
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = '0;
      next_st.rresp = RESP_SLVERR;
      if (mapped(ra) && !(is_ext(ra) && st.ext_sel)) begin
        next_st.rdata = reg_read(ra, st);
        next_st.rresp = RESP_OKAY;
      end
    end else if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
    next_st.second_set = sel.second;
    c = speed_code(sel.extra, sel.high, sel.mid, sel.low);
    if (c != 4'h0 && st.speed[c - 4'h1] != CODE_OFF) begin
      next_st.speed_no = c;
    end else if (sel.low) begin
      next_st.speed_no = SPEED_NO_LOW;
    end else if (sel.mid) begin
      next_st.speed_no = SPEED_NO_MID;
    end else if (sel.high) begin
      next_st.speed_no = SPEED_NO_HIGH;
    end else if (sel.extra) begin
      next_st.speed_no = SPEED_NO_LOW;
    end else begin
      next_st.speed_no = 4'h0;
    end
    if (jog_active) begin
      next_st.freq_cmd = jog_freq;
    end else if (next_st.speed_no != 4'h0) begin
      next_st.freq_cmd = st.speed[next_st.speed_no - 4'h1];
    end else if (analog2_valid) begin
      next_st.freq_cmd = analog2_freq;
    end else begin
      next_st.freq_cmd = analog1_freq;
    end
    // The divide takes tens of cycles; the voltage follows the ramped
    // output frequency, which changes far more slowly than that.
    unique case (st.vst)
      VS_IDLE: begin
        next_st.vbase = eff_vb;
        next_st.vf = out_freq;
        next_st.vbf = eff_bf;
        if (eff_bf == '0 || out_freq >= eff_bf) begin
          next_st.volt_cmd = eff_vb;
        end else begin
          next_st.vst = VS_DIV;
          next_st.div_go = 1'b1;
        end
      end
      VS_DIV: begin
        next_st.div_go = 1'b0;
        if (div_done) begin
          next_st.ratio = quot[RATIO_W-1:0];
          next_st.vst = VS_OUT;
        end
      end
      VS_OUT: begin
        p = 36'(st.vbase) * 36'(st.ratio);
        p2 = 36'(p[22:0]) * 36'(st.ratio);
        if (st.load_pat) begin
          next_st.volt_cmd = VOUT_W'(p2 >> (2 * RATIO_FRAC));
        end else begin
          next_st.volt_cmd = VOUT_W'(p >> RATIO_FRAC);
        end
        next_st.vst = VS_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.ext_sel <= EXT_SEL_RST;
      st.wr_sel <= WR_SEL_RST;
      st.load_pat <= LOAD_PAT_RST;
      st.termfn <= TERMFN_RST;
      st.bfreq <= BASE_FREQ_RST;
      st.bvolt <= BASE_VOLT_RST;
      st.bfreq2 <= BASE_FREQ2_RST;
      st.speed <= {NSPEED{SPEED_EXT_RST}};
      st.speed[0] <= SPEED_HIGH_RST;
      st.speed[1] <= SPEED_MID_RST;
      st.speed[2] <= SPEED_LOW_RST;
      st.vst <= VS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  vfms_div #(
    .NW(DIV_NW),
    .DW(SET_W)
  ) i_vfms_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(st.div_go),
    .num({st.vf, 12'h000}),
    .den(st.vbf),
    .quot(quot),
    .done(div_done)
  );

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign freq_cmd = st.freq_cmd;
  assign speed_no = st.speed_no;
  assign volt_cmd = st.volt_cmd;
  assign second_set = st.second_set;

  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_base_reset: assert property (
    @(posedge aclk) disable iff (1'b0)
      !aresetn |=> st.bfreq == BASE_FREQ_RST &&
      st.bvolt == CODE_OFF && st.load_pat)
    else $error("Base settings wrong after reset.");
  chk_volt_95pct: assert property (
    (st.vst == VS_IDLE && st.bvolt == CODE_SUPPLY95 && eff_bf != '0 &&
     out_freq >= eff_bf) |=> volt_cmd == $past(v95))
    else $error("Base voltage is not 95 percent of supply.");
  chk_volt_supply: assert property (
    (st.vst == VS_IDLE && st.bvolt == CODE_OFF && eff_bf != '0 &&
     out_freq >= eff_bf) |=> volt_cmd == $past(supply_volt))
    else $error("Base voltage does not equal supply.");
  chk_volt_cap: assert property (
    ($changed(st.bvolt) && st.bvolt <= VOLT_MAX) |->
      ##[1:64] volt_cmd <= st.bvolt[VOUT_W-1:0])
    else $error("Output voltage exceeds programmed base voltage.");
  chk_second_base: assert property (
    (second_set && st.bfreq2 != CODE_OFF && st.vst == VS_IDLE) |=>
      st.vbf == $past(st.bfreq2))
    else $error("Second base frequency not used.");
  chk_second_out: assert property (
    $rose(sel.second) |=> second_set ##1 (second_set || !$past(sel.second)))
    else $error("Second-set output does not follow its input.");
  chk_low_wins: assert property (
    (!jog_active && sel.low && sel.mid && !sel.high && !sel.extra &&
     st.speed[3] == CODE_OFF) |=> freq_cmd == $past(st.speed[2]))
    else $error("Lower-speed preset did not win.");
  chk_speed8_off: assert property (
    (!jog_active && sel.extra && !sel.low && !sel.mid && !sel.high &&
     st.speed[7] == CODE_OFF) |=> speed_no == SPEED_NO_LOW)
    else $error("Extra input alone did not fall back to low preset.");
  chk_jog_first: assert property (
    jog_active |=> freq_cmd == $past(jog_freq))
    else $error("Jog frequency did not take priority.");
  chk_preset_run: assert property (
    (wr_do && motor_running && !st.wr_sel && is_speed(wr_a) &&
     !(is_ext(wr_a) && st.ext_sel) && st.wstrb == 4'hF &&
     legal(wr_a, st.wdata)) |=> bvalid && bresp == RESP_OKAY)
    else $error("Preset write refused while running.");
  chk_ext_lock: assert property (
    (wr_do && st.ext_sel && is_ext(wr_a)) |=>
      bresp == RESP_SLVERR && $stable(st.bvolt) && $stable(st.bfreq2))
    else $error("Extended setting reachable while locked.");
  chk_knee_hold: assert property (
    (st.vst == VS_IDLE && eff_bf != '0 && out_freq >= eff_bf) |=>
      volt_cmd == $past(eff_vb))
    else $error("Voltage not held above base frequency.");
endmodule

// File: vfms_switch.sv
// Contact-switch model that drives the terminal inputs.
`timescale 1ns/1ps
module vfms_switch import vfms_pkg::*; (
  input wire logic aclk,
  input wire vfms_sel_t sel,
  output logic [NTERM-1:0] term_in
);
  // Contacts change just after an edge, like a controller output stage.
  // Wiring follows the reset terminal functions, so a changed map breaks it.
  initial term_in = '0;
  always @(posedge aclk) begin
    term_in <= {sel.extra, sel.second, sel.high, sel.mid, sel.low};
  end
endmodule

// File: vfms_core_tb.sv
// Self-checking bench for the V/F and multi-speed block.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module vfms_core_tb import vfms_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, second_set;
  logic motor_running, jog_active, analog2_valid;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, speed_no;
  logic [1:0] bresp, rresp;
  logic [NTERM-1:0] term_in;
  logic [SET_W-1:0] jog_freq, analog1_freq, analog2_freq, out_freq, freq_cmd;
  logic [VOUT_W-1:0] supply_volt, volt_cmd;
  vfms_sel_t sel;
  int err_count = 0;
  int check_count = 0;
  // Row: {extra,high,middle,low}, expected speed number (F skips), frequency.
  logic [21:0] rows [8] = '{{4'h4, 4'h1, 14'h0258}, {4'h2, 4'h2, 14'h012C},
    {4'h1, 4'h3, 14'h0064}, {4'h6, 4'hF, 14'h012C}, {4'h7, 4'hF, 14'h0064},
    {4'h8, 4'hF, 14'h0064}, {4'h3, 4'h3, 14'h0064}, {4'h0, 4'h0, 14'h0111}};

  vfms_core i_vfms_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .term_in(term_in),
    .motor_running(motor_running), .jog_active(jog_active),
    .jog_freq(jog_freq), .analog1_freq(analog1_freq),
    .analog2_freq(analog2_freq), .analog2_valid(analog2_valid),
    .out_freq(out_freq), .supply_volt(supply_volt), .freq_cmd(freq_cmd),
    .speed_no(speed_no), .volt_cmd(volt_cmd), .second_set(second_set));
  vfms_switch i_vfms_switch (.aclk(aclk), .sel(sel), .term_in(term_in));

  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic hung;
    err_count++;
    summarize();
  endtask

  // Both channels are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) hung();
    `CHK(bresp, er)
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) hung();
    `CHK(rdata, ed)
    `CHK(rresp, er)
    @(posedge aclk);
  endtask

  // The pattern takes tens of cycles, so the wait is bounded well above it.
  task automatic vchk(input logic [VOUT_W-1:0] e);
    int n;
    n = 0;
    while (volt_cmd !== e && n < 80) begin
      @(posedge aclk);
      n++;
    end
    `CHK(volt_cmd, e)
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {motor_running, jog_active, awaddr, araddr, wdata, wstrb} = '0;
    {awprot, arprot, sel, out_freq} = '0;
    jog_freq = 14'h0005;
    analog1_freq = 14'h0222;
    analog2_freq = 14'h0111;
    analog2_valid = 1'b1;
    supply_volt = 10'h0C8;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    `CHK(volt_cmd, 10'h000)
    `CHK(speed_no, 4'h0)
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_BASE_FREQ, 32'h00000258, RESP_OKAY);
    rd(OFS_BASE_VOLT, 32'h0000270F, RESP_OKAY);
    rd(OFS_BASE_FREQ2, 32'h0000270F, RESP_OKAY);
    rd(OFS_LOAD, 32'h00000001, RESP_OKAY);
    rd(OFS_TERMFN, 32'h00083210, RESP_OKAY);
    wr(OFS_TERMFN, 32'h00083210, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      {sel.extra, sel.high, sel.mid, sel.low} <= rows[i][21:18];
      repeat (3) @(posedge aclk);
      `CHK(freq_cmd, rows[i][13:0])
      if (rows[i][17:14] != 4'hF) `CHK(speed_no, rows[i][17:14])
    end
    analog2_valid <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(freq_cmd, 14'h0222)
    jog_active <= 1'b1;
    sel <= 5'h10;
    repeat (3) @(posedge aclk);
    `CHK(freq_cmd, 14'h0005)
    jog_active <= 1'b0;
    sel <= 5'h14;
    wr(OFS_SPEED + 8'h10, 32'h000004D2, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(freq_cmd, 14'h04D2)
    `CHK(speed_no, 4'h5)
    wr(OFS_CTRL, 32'h00000001, RESP_OKAY);
    wr(OFS_SPEED + 8'h10, 32'h00000064, RESP_SLVERR);
    rd(OFS_LOAD, 32'h00000000, RESP_SLVERR);
    wr(OFS_CTRL, 32'h00000000, RESP_OKAY);
    `CHK(freq_cmd, 14'h04D2)
    sel <= 5'h0C;
    wr(OFS_SPEED + 8'h0C, 32'h000003E8, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK(speed_no, 4'h4)
    `CHK(freq_cmd, 14'h03E8)
    wr(OFS_BASE_FREQ, 32'h00000FA1, RESP_SLVERR);
    wr(OFS_BASE_VOLT, 32'h000003E9, RESP_SLVERR);
    wr(OFS_VOUT, 32'h00000000, RESP_SLVERR);
    rd(8'h80, 32'h00000000, RESP_SLVERR);
    out_freq <= 14'h02BC;
    vchk(10'h0C8);
    wr(OFS_LOAD, 32'h00000000, RESP_OKAY);
    out_freq <= 14'h012C;
    vchk(10'h064);
    wr(OFS_LOAD, 32'h00000001, RESP_OKAY);
    vchk(10'h032);
    wr(OFS_BASE_VOLT, 32'h000022B8, RESP_OKAY);
    out_freq <= 14'h02BC;
    vchk(10'h0BE);
    wr(OFS_BASE_VOLT, 32'h00000096, RESP_OKAY);
    vchk(10'h096);
    wr(OFS_BASE_FREQ2, 32'h0000012C, RESP_OKAY);
    sel.second <= 1'b1;
    out_freq <= 14'h0096;
    vchk(10'h025);
    `CHK(second_set, 1'b1)
    motor_running <= 1'b1;
    wr(OFS_BASE_FREQ, 32'h000001F4, RESP_SLVERR);
    wr(OFS_SPEED, 32'h000001F4, RESP_OKAY);
    sel <= 5'h10;
    repeat (3) @(posedge aclk);
    `CHK(freq_cmd, 14'h01F4)
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(speed_no, 4'h0)
    `CHK(volt_cmd, 10'h000)
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_SPEED, 32'h00000258, RESP_OKAY);
    rd(OFS_BASE_VOLT, 32'h0000270F, RESP_OKAY);
    `CHK(freq_cmd, 14'h0258)
    summarize();
  end
endmodule
